// File: rtl/ee_spi_dev.sv
`timescale 1ns/1ns
`default_nettype none
module ee_spi_dev #(
  parameter int unsigned   WRITE_CYCLE_CYC = ee_pkg::TWC_CYC,
  parameter logic [39:0]   ID_VALUE        = 40'h1122334455, // arbitrary value
  parameter logic [127:0]  SERIAL_VALUE    = 128'h00112233445566778899AABBCCDDEEFF // arbitrary
) (
  input  wire logic           ref_clk,
  input  wire logic           rstn,
  input  wire logic           cs_n,
  input  wire logic           sck,
  input  wire logic           si,
  input  wire logic           hold_n,
  input  wire logic           wp_n,
  output logic                so,
  output logic                so_oe,
  output logic                standby,
  output logic [18:0]         mem_raddr,
  input  wire logic [7:0]     mem_rdata,
  input  wire logic           ecc_corrected,
  output logic                wr_valid,
  input  wire logic           wr_ready,
  output ee_pkg::ee_wr_s      wr_word
);
  localparam int unsigned CW = $clog2(WRITE_CYCLE_CYC + 1);

  logic [1:0]        rst_sync;
  logic              rst_n;
  ee_pkg::ee_pins_s  pin_meta;
  ee_pkg::ee_pins_s  pin_q;
  logic              sck_d;
  logic              sel_d;
  logic              sel;
  logic              hold_on;
  logic              sck_rise;
  logic              sck_fall;
  logic              frame_end;
  logic [2:0]        bit_cnt;
  logic [7:0]        rx_sh;
  logic [7:0]        rx_byte;
  logic              byte_done;
  logic [7:0]        out_sh;
  logic [7:0]        tx_byte;
  ee_pkg::ee_phase_e ph;
  logic [7:0]        opcode;
  logic [1:0]        addr_cnt;
  logic [18:0]       addr;
  logic [2:0]        idx;
  logic              wrote;
  logic              lock_en;
  logic [1:0]        bp;
  logic              write_enable_latch;
  logic              busy;
  logic [CW-1:0]     busy_cnt;
  logic              scheme;
  logic              ecc;
  logic              freeze;
  logic              partition_write_latch;
  logic              blk;
  logic [7:0]        part [8];
  logic [7:0]        user_page [256];
  logic              sec_lock;
  logic [7:0]        st0;
  logic [7:0]        st1;
  logic              data_byte;
  logic              status_guarded;
  logic              do_wrsr0;
  logic              do_wrsr1;
  logic              do_write;
  logic              do_sec;
  logic              do_lock;
  logic              do_wmpr;
  ee_pkg::ee_wr_s    fifo [2];
  logic              f_wp;
  logic              f_rp;
  logic [1:0]        f_cnt;
  logic              f_ready;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // pins come from the host's domain and pass two flops first
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= ee_pkg::PINS_IDLE;
      pin_q    <= ee_pkg::PINS_IDLE;
      sck_d    <= 1'b0;
      sel_d    <= 1'b0;
    end else begin
      pin_meta <= {cs_n, sck, si, hold_n, wp_n};
      pin_q    <= pin_meta;
      sck_d    <= pin_q.sck;
      sel_d    <= sel;
    end
  end

  assign sel       = !pin_q.cs_n;
  assign frame_end = !sel && sel_d;
  assign hold_on   = sel && !pin_q.hold_n;
  assign sck_rise  = sel && !hold_on && pin_q.sck && !sck_d;
  assign sck_fall  = sel && !hold_on && !pin_q.sck && sck_d;
  assign rx_byte   = {rx_sh[6:0], pin_q.si};
  assign byte_done = sck_rise && (bit_cnt == 3'h7);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt <= 3'h0;
      rx_sh   <= 8'h00;
    end else if (!sel) begin
      bit_cnt <= 3'h0;
    end else if (sck_rise) begin
      bit_cnt <= bit_cnt + 3'h1;
      rx_sh   <= rx_byte;
    end
  end

  function automatic logic [7:0] sec_byte(input logic [18:0] a);
    if (a[8]) begin
      sec_byte = user_page[a[7:0]];
    end else if (a[7:4] == 4'h0) begin
      sec_byte = SERIAL_VALUE[{~a[3:0], 3'b000} +: 8];
    end else begin
      sec_byte = ee_pkg::RSV_BYTE;
    end
  endfunction

  function automatic logic [7:0] id_byte(input logic [2:0] i);
    if (i > ee_pkg::ID_LAST) begin
      id_byte = ee_pkg::RSV_BYTE;
    end else begin
      id_byte = ID_VALUE[{3'(ee_pkg::ID_LAST - i), 3'b000} +: 8];
    end
  endfunction

  function automatic logic array_guarded(input logic [18:0] a);
    logic       hit;
    logic [1:0] beh;
    hit = 1'b0;
    beh = part[7][7:6];
    for (int i = 0; i < 8; i++) begin
      if (!hit && a[18:13] <= part[i][5:0]) begin
        hit = 1'b1;
        beh = part[i][7:6];
      end
    end
    if (scheme) begin
      case (beh)
        ee_pkg::PB_OPEN: array_guarded = 1'b0;
        ee_pkg::PB_PIN:  array_guarded = !pin_q.wp_n;
        default:         array_guarded = 1'b1;
      endcase
    end else begin
      case (bp)
        ee_pkg::BP_QUARTER: array_guarded = a >= ee_pkg::QUARTER_BASE;
        ee_pkg::BP_HALF:    array_guarded = a >= ee_pkg::HALF_BASE;
        ee_pkg::BP_ALL:     array_guarded = 1'b1;
        default:            array_guarded = 1'b0;
      endcase
    end
  endfunction

  // sequence state survives pauses because every step waits for an unpaused edge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ph       <= ee_pkg::PH_CMD;
      opcode   <= 8'h00;
      addr_cnt <= 2'h0;
      addr     <= 19'h00000;
      idx      <= 3'h0;
    end else if (!sel) begin
      ph       <= ee_pkg::PH_CMD;
      addr_cnt <= 2'h0;
      idx      <= 3'h0;
    end else if (byte_done) begin
      case (ph)
        ee_pkg::PH_CMD: begin
          opcode <= rx_byte;
          if (busy && rx_byte != ee_pkg::OP_RDSR) begin
            ph <= ee_pkg::PH_IGNORE;
          end else begin
            case (rx_byte)
              ee_pkg::OP_RDSR, ee_pkg::OP_WRSR, ee_pkg::OP_SPID: ph <= ee_pkg::PH_DATA;
              ee_pkg::OP_READ, ee_pkg::OP_WRITE, ee_pkg::OP_RDEX, ee_pkg::OP_WREX,
              ee_pkg::OP_RMPR, ee_pkg::OP_WMPR: ph <= ee_pkg::PH_ADDR;
              default: ph <= ee_pkg::PH_IGNORE;
            endcase
          end
        end
        ee_pkg::PH_ADDR: begin
          addr     <= {addr[10:0], rx_byte};
          addr_cnt <= addr_cnt + 2'h1;
          if (addr_cnt == 2'h2) begin
            ph <= ee_pkg::PH_DATA;
          end
        end
        ee_pkg::PH_DATA: begin
          if (idx != 3'h7) begin
            idx <= idx + 3'h1;
          end
          if (opcode == ee_pkg::OP_READ || opcode == ee_pkg::OP_RDEX) begin
            addr <= addr + 19'h00001;
          end else if (opcode == ee_pkg::OP_WRITE || opcode == ee_pkg::OP_WREX) begin
            addr <= {addr[18:8], addr[7:0] + 8'h01};
          end
        end
        default: ph <= ee_pkg::PH_IGNORE;
      endcase
    end
  end

  assign st0 = {lock_en, 3'b000, bp, write_enable_latch, busy};
  assign st1 = {scheme, ecc, freeze, partition_write_latch, blk, 2'b00, busy};
  assign status_guarded = lock_en && !pin_q.wp_n;
  assign data_byte = byte_done && ph == ee_pkg::PH_DATA;
  assign do_wrsr0 = data_byte && opcode == ee_pkg::OP_WRSR && write_enable_latch
                    && !status_guarded && idx == 3'h0;
  assign do_wrsr1 = data_byte && opcode == ee_pkg::OP_WRSR && write_enable_latch
                    && !status_guarded && idx == 3'h1;
  assign do_write = data_byte && opcode == ee_pkg::OP_WRITE && write_enable_latch
                    && !array_guarded(addr) && f_ready;
  assign do_lock  = data_byte && opcode == ee_pkg::OP_WREX && write_enable_latch && !sec_lock
                    && addr == ee_pkg::SEC_LOCK_ADDR;
  assign do_sec   = data_byte && opcode == ee_pkg::OP_WREX && write_enable_latch && !sec_lock
                    && addr[18:8] == 11'h001;
  assign do_wmpr  = data_byte && opcode == ee_pkg::OP_WMPR && write_enable_latch
                    && partition_write_latch && !freeze
                    && part[addr[2:0]][7:6] != ee_pkg::PB_LOCK;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrote <= 1'b0;
    end else if (!sel) begin
      wrote <= 1'b0;
    end else if (do_wrsr0 || do_wrsr1 || do_write || do_lock || do_sec || do_wmpr) begin
      wrote <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_en <= 1'b0;
      bp      <= 2'h0;
      scheme  <= 1'b0;
      freeze  <= 1'b0;
      blk     <= 1'b0;
    end else if (do_wrsr0) begin
      lock_en <= rx_byte[ee_pkg::S0_LOCK];
      bp      <= {rx_byte[ee_pkg::S0_BPH], rx_byte[ee_pkg::S0_BPL]};
    end else if (do_wrsr1) begin
      if (!freeze) begin
        scheme <= rx_byte[ee_pkg::S1_SCHEME];
      end
      freeze <= freeze | rx_byte[ee_pkg::S1_FREEZE];
      blk    <= blk | rx_byte[ee_pkg::S1_BLOCK];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      write_enable_latch <= 1'b0;
    end else if (frame_end && wrote) begin
      write_enable_latch <= 1'b0;
    end else if (byte_done && ph == ee_pkg::PH_CMD && !busy) begin
      if (rx_byte == ee_pkg::OP_WREN) begin
        write_enable_latch <= 1'b1;
      end else if (rx_byte == ee_pkg::OP_WRDI) begin
        write_enable_latch <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      partition_write_latch <= 1'b0;
    end else if (frame_end && wrote) begin
      partition_write_latch <= 1'b0;
    end else if (byte_done && ph == ee_pkg::PH_CMD && !busy) begin
      if (rx_byte == ee_pkg::OP_PRWE) begin
        partition_write_latch <= 1'b1;
      end else if (rx_byte == ee_pkg::OP_PRWD) begin
        partition_write_latch <= 1'b0;
      end
    end
  end

  // a correction report at the end of a status read still sets the flag
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ecc <= 1'b0;
    end else if (ecc_corrected) begin
      ecc <= 1'b1;
    end else if (frame_end && opcode == ee_pkg::OP_RDSR) begin
      ecc <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++) begin
        part[i] <= ee_pkg::PART_RESET;
      end
    end else if (do_wmpr) begin
      part[addr[2:0]] <= blk ? {rx_byte[7:6], part[addr[2:0]][5:0]} : rx_byte;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sec_lock <= 1'b0;
    end else if (do_lock) begin
      sec_lock <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 256; i++) begin
        user_page[i] <= ee_pkg::RSV_BYTE;
      end
    end else if (do_sec) begin
      user_page[addr[7:0]] <= rx_byte;
    end
  end

  // write cycle waits for the buffer to drain, so a slow receiver holds busy
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy     <= 1'b0;
      busy_cnt <= '0;
    end else if (frame_end && wrote) begin
      busy     <= 1'b1;
      busy_cnt <= '0;
    end else if (busy && f_cnt == 2'h0) begin
      if (busy_cnt == CW'(WRITE_CYCLE_CYC - 1)) begin
        busy <= 1'b0;
      end else begin
        busy_cnt <= busy_cnt + CW'(1);
      end
    end
  end

  assign f_ready = f_cnt != 2'h2;
  assign wr_valid = f_cnt != 2'h0;
  assign wr_word = fifo[f_rp];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      f_wp  <= 1'b0;
      f_rp  <= 1'b0;
      f_cnt <= 2'h0;
    end else begin
      if (do_write) begin
        f_wp <= !f_wp;
      end
      if (wr_valid && wr_ready) begin
        f_rp <= !f_rp;
      end
      f_cnt <= f_cnt + {1'b0, do_write} - {1'b0, wr_valid && wr_ready};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (do_write) begin
      fifo[f_wp] <= '{addr: addr, data: rx_byte};
    end
  end

  always_comb begin
    tx_byte = 8'h00;
    case (opcode)
      ee_pkg::OP_RDSR: tx_byte = idx[0] ? st1 : st0;
      ee_pkg::OP_SPID: tx_byte = id_byte(idx);
      ee_pkg::OP_READ: tx_byte = mem_rdata;
      ee_pkg::OP_RDEX: tx_byte = sec_byte(addr);
      ee_pkg::OP_RMPR: tx_byte = part[addr[2:0]];
      default:         tx_byte = 8'h00;
    endcase
    if (ph != ee_pkg::PH_DATA) begin
      tx_byte = 8'h00;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      so     <= 1'b0;
      out_sh <= 8'h00;
    end else if (sck_fall) begin
      if (bit_cnt == 3'h0) begin
        so     <= tx_byte[7];
        out_sh <= {tx_byte[6:0], 1'b0};
      end else begin
        so     <= out_sh[7];
        out_sh <= {out_sh[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      so_oe     <= 1'b0;
      standby   <= 1'b1;
      mem_raddr <= 19'h00000;
    end else begin
      so_oe     <= sel && !hold_on;
      standby   <= !sel && !busy;
      mem_raddr <= addr;
    end
  end

  AST_DESEL_HIZ: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(pin_q.cs_n) |=> !so_oe && !byte_done)
    else $error("output driven or byte taken after deselect");

  AST_HOLD_HIZ: assert property (@(posedge ref_clk) disable iff (!rst_n)
    hold_on |=> !so_oe)
    else $error("output driven while paused");

  AST_SO_ON_FALL: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $changed(so) |-> $past(sck_fall))
    else $error("output changed without a falling clock");

  AST_RX_ON_RISE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $changed(bit_cnt) |-> $past(sck_rise) || !$past(sel))
    else $error("bit count moved without a rising clock");

  AST_HOLD_KEEPS: assert property (@(posedge ref_clk) disable iff (!rst_n)
    hold_on && sel ##1 sel |-> $stable(bit_cnt) && $stable(ph) && $stable(addr))
    else $error("sequence state changed during pause");

  AST_BUSY_AFTER_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    frame_end && wrote |=> busy ##1 !standby)
    else $error("no write cycle after a write sequence");

  AST_PAGE_WRAP: assert property (@(posedge ref_clk) disable iff (!rst_n)
    do_write |=> addr[18:8] == $past(addr[18:8]) && addr[7:0] == $past(addr[7:0]) + 8'h01)
    else $error("page write left its page");

  AST_RSV_ZERO: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st0[6:4] == 3'h0 && st1[2:1] == 2'h0 && st0[0] == st1[0])
    else $error("reserved status bits not zero");

  AST_STATUS_GUARD: assert property (@(posedge ref_clk) disable iff (!rst_n)
    lock_en && !pin_q.wp_n |=> $stable(bp) && $stable(lock_en))
    else $error("guarded status register changed");

  AST_PART_ZERO_OPEN: assert property (@(posedge ref_clk) disable iff (!rst_n)
    scheme && {part[0], part[1], part[2], part[3]} == 32'h0
    && {part[4], part[5], part[6], part[7]} == 32'h0 |-> !array_guarded(addr))
    else $error("zeroed partitions guard the array");
endmodule
`default_nettype wire

// File: rtl/ee_pkg.sv
package ee_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned TWC_MS = 5;
  localparam int unsigned TWC_CYC = CLK_HZ / 1000 * TWC_MS;
  localparam int unsigned ADDR_W = 19;
  localparam int unsigned PAGE_BYTES = 256;
  localparam int unsigned PAGE_COUNT = 2048;
  localparam logic [7:0] OP_WRSR = 8'h01;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_RDSR = 8'h05;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_PRWE = 8'h07;
  localparam logic [7:0] OP_PRWD = 8'h0A;
  localparam logic [7:0] OP_RMPR = 8'h31;
  localparam logic [7:0] OP_WMPR = 8'h32;
  localparam logic [7:0] OP_WREX = 8'h82;
  localparam logic [7:0] OP_RDEX = 8'h83;
  localparam logic [7:0] OP_SPID = 8'h9F;
  localparam int unsigned S0_LOCK = 7;
  localparam int unsigned S0_BPH = 3;
  localparam int unsigned S0_BPL = 2;
  localparam int unsigned S1_SCHEME = 7;
  localparam int unsigned S1_FREEZE = 5;
  localparam int unsigned S1_BLOCK = 3;
  localparam logic [1:0] PB_OPEN = 2'h0;
  localparam logic [1:0] PB_SW = 2'h1;
  localparam logic [1:0] PB_PIN = 2'h2;
  localparam logic [1:0] PB_LOCK = 2'h3;
  localparam logic [1:0] BP_QUARTER = 2'h1;
  localparam logic [1:0] BP_HALF = 2'h2;
  localparam logic [1:0] BP_ALL = 2'h3;
  localparam logic [18:0] QUARTER_BASE = 19'h60000;
  localparam logic [18:0] HALF_BASE = 19'h40000;
  localparam logic [18:0] SEC_LOCK_ADDR = 19'h00400;
  localparam logic [7:0] RSV_BYTE = 8'hFF;
  localparam logic [7:0] PART_RESET = 8'h00;
  localparam logic [2:0] ID_LAST = 3'h4;
  typedef enum {PH_CMD, PH_ADDR, PH_DATA, PH_IGNORE} ee_phase_e;
  typedef struct packed {
    logic [18:0] addr;
    logic [7:0]  data;
  } ee_wr_s;
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic hold_n;
    logic wp_n;
  } ee_pins_s;
  localparam ee_pins_s PINS_IDLE = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, hold_n: 1'b1, wp_n: 1'b1};
endpackage

// File: dv/ee_host.sv
`timescale 1ns/1ns
`default_nettype none
module ee_host (
  input  wire logic        ref_clk,
  input  wire logic        so,
  input  wire logic        so_oe,
  output ee_pkg::ee_pins_s pins
);
  initial pins = ee_pkg::PINS_IDLE;

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic open();
    pins.cs_n = 1'b0;
    tick(4);
  endtask

  // released data line shows the inverse of its last bit
  task automatic close();
    tick(4);
    pins.cs_n = 1'b1;
    pins.si = ~pins.si;
    tick(12);
  endtask

  // sck half period is 4 ref_clk cycles (80 ns), mode 0
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, input bit pause);
    for (int i = 7; i >= 0; i--) begin
      pins.si = tx[i];
      tick(4);
      pins.sck = 1'b1;
      rx[i] = so_oe ? so : ~so;
      tick(4);
      pins.sck = 1'b0;
      if (pause && i == 4) begin
        tick(4);
        pins.hold_n = 1'b0;
        tick(12);
        pins.hold_n = 1'b1;
        tick(4);
      end
    end
  endtask
endmodule
`default_nettype wire

// File: dv/spi_eeprom_pins_and_registers_test.sv
`timescale 1ns/1ns
`default_nettype none
module spi_eeprom_pins_and_registers_test;
  localparam logic [39:0]  ID = 40'hA1B2C3D4E5; // arbitrary value
  localparam logic [127:0] SN = 128'h5AC3_0000_0000_0000_0000_0000_0000_C35A; // arbitrary value
  logic             ref_clk;
  logic             rstn;
  logic             so;
  logic             so_oe;
  logic             standby;
  logic [18:0]      mem_raddr;
  logic [7:0]       mem_rdata = 8'h00;
  logic             ecc;
  logic             wr_valid;
  logic             wr_ready;
  ee_pkg::ee_wr_s   wr_word;
  ee_pkg::ee_pins_s pins;
  ee_pkg::ee_wr_s   got_q[$];
  logic [7:0]       rd[$];
  int               fails = 0;
  int               tests_run = 0;
  int               hc = 0;

  ee_spi_dev #(.WRITE_CYCLE_CYC(20), .ID_VALUE(ID), .SERIAL_VALUE(SN)) DUT (
    .ref_clk(ref_clk), .rstn(rstn), .cs_n(pins.cs_n), .sck(pins.sck), .si(pins.si),
    .hold_n(pins.hold_n), .wp_n(pins.wp_n), .so(so), .so_oe(so_oe), .standby(standby),
    .mem_raddr(mem_raddr), .mem_rdata(mem_rdata), .ecc_corrected(ecc),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_word(wr_word)
  );
  ee_host host (.ref_clk(ref_clk), .so(so), .so_oe(so_oe), .pins(pins));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // array stand-in: data is a function of the address, one cycle late
  always @(posedge ref_clk) begin
    mem_rdata <= mem_raddr[7:0] ^ 8'h5A;
    if (wr_valid === 1'b1 && wr_ready === 1'b1) got_q.push_back(wr_word);
    hc <= (pins.cs_n || !pins.hold_n) ? hc + 1 : 0;
    if (hc == 6) check(so_oe, 0);
  end

  always @(so) if (so_oe === 1'b1) check(pins.sck, 0);

  task automatic check(input logic [39:0] got, input logic [39:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("errors %0d of %0d compares", fails, tests_run);
    if (fails == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic frame(input logic [7:0] tx[$], input int n, input bit pause);
    logic [7:0] b;
    rd = {};
    host.open();
    for (int k = 0; k < n; k++) begin
      host.xfer(k < tx.size() ? tx[k] : 8'h00, b, pause && k == 2);
      rd.push_back(b);
    end
    host.close();
  endtask

  task automatic settle();
    for (int i = 0; i < 400 && standby !== 1'b1; i++) tick(1);
    check(standby, 1);
  endtask

  task automatic status(input logic [7:0] e0, input logic [7:0] e1);
    frame({ee_pkg::OP_RDSR}, 3, 0);
    check({rd[1], rd[2]}, {e0, e1});
  endtask

  task automatic t_regs();
    for (int k = 0; k < 8; k++) begin
      frame({ee_pkg::OP_RMPR, 8'h00, 8'h00, 8'(k)}, 5, 0);
      check(rd[4], 0);
    end
    frame({ee_pkg::OP_SPID}, 6, 0);
    check({rd[1], rd[2], rd[3], rd[4], rd[5]}, ID);
    frame({ee_pkg::OP_RDEX, 8'h00, 8'h00, 8'h0E}, 8, 0);
    check({rd[4], rd[5], rd[6], rd[7]}, 32'hC35AFFFF);
    frame({ee_pkg::OP_READ, 8'h00, 8'h01, 8'h23}, 6, 0);
    check({rd[4], rd[5]}, 16'h797E);
  endtask

  task automatic t_hold_deselect();
    logic [7:0] b;
    frame({ee_pkg::OP_SPID}, 6, 1);
    check({rd[1], rd[2], rd[3], rd[4], rd[5]}, ID);
    host.xfer(ee_pkg::OP_WREN, b, 0);
    host.close();
    status(8'h00, 8'h00);
  endtask

  task automatic t_write();
    wr_ready = 1'b0;
    frame({ee_pkg::OP_WRITE, 8'h00, 8'h01, 8'hFF, 8'hA1}, 5, 0);
    tick(40);
    check(got_q.size(), 0);
    frame({ee_pkg::OP_WREN}, 1, 0);
    status(8'h02, 8'h00);
    frame({ee_pkg::OP_WRITE, 8'h00, 8'h01, 8'hFF, 8'hA1, 8'hB2}, 6, 0);
    check({wr_valid, standby}, 2'b10);
    status(8'h01, 8'h01);
    wr_ready = 1'b1;
    settle();
    check(got_q[0], {19'h001FF, 8'hA1});
    check(got_q[1], {19'h00100, 8'hB2});
    status(8'h00, 8'h00);
  endtask

  task automatic t_ecc();
    ecc = 1'b1;
    tick(1);
    ecc = 1'b0;
    status(8'h00, 8'h40);
    status(8'h00, 8'h00);
  endtask

  task automatic t_legacy();
    frame({ee_pkg::OP_WREN}, 1, 0);
    frame({ee_pkg::OP_WRSR, 8'hFC}, 2, 0);
    settle();
    status(8'h8C, 8'h00);
    host.pins.wp_n = 1'b0;
    frame({ee_pkg::OP_WREN}, 1, 0);
    frame({ee_pkg::OP_WRSR, 8'h00}, 2, 0);
    settle();
    status(8'h8E, 8'h00);
    frame({ee_pkg::OP_WRITE, 8'h00, 8'h00, 8'h00, 8'h77}, 5, 0);
    tick(40);
    check(got_q.size(), 2);
  endtask

  task automatic t_enhanced();
    host.pins.wp_n = 1'b1;
    frame({ee_pkg::OP_WRDI}, 1, 0);
    status(8'h8C, 8'h00);
    frame({ee_pkg::OP_WREN}, 1, 0);
    frame({ee_pkg::OP_WRSR, 8'h00, 8'h80}, 3, 0);
    settle();
    status(8'h00, 8'h80);
    frame({ee_pkg::OP_WREN}, 1, 0);
    frame({ee_pkg::OP_WRITE, 8'h07, 8'h00, 8'h05, 8'h3C}, 5, 0);
    settle();
    check(got_q[2], {19'h70005, 8'h3C});
    frame({ee_pkg::OP_PRWE}, 1, 0);
    status(8'h00, 8'h90);
    frame({ee_pkg::OP_PRWD}, 1, 0);
    status(8'h00, 8'h80);
    frame({ee_pkg::OP_PRWE}, 1, 0);
    frame({ee_pkg::OP_WREN}, 1, 0);
    frame({ee_pkg::OP_WMPR, 8'h00, 8'h00, 8'h00, 8'h80}, 5, 0);
    settle();
    frame({ee_pkg::OP_RMPR, 8'h00, 8'h00, 8'h00}, 5, 0);
    check(rd[4], 8'h80);
    host.pins.wp_n = 1'b0;
    frame({ee_pkg::OP_WREN}, 1, 0);
    frame({ee_pkg::OP_WRITE, 8'h00, 8'h00, 8'h10, 8'h11}, 5, 0);
    tick(40);
    check(got_q.size(), 3);
    host.pins.wp_n = 1'b1;
    frame({ee_pkg::OP_WRITE, 8'h00, 8'h00, 8'h10, 8'h22}, 5, 0);
    settle();
    check(got_q[3], {19'h00010, 8'h22});
    frame({ee_pkg::OP_WREN}, 1, 0);
    frame({ee_pkg::OP_WREX, 8'h00, 8'h01, 8'h05, 8'h6B}, 5, 0);
    settle();
    frame({ee_pkg::OP_WREN}, 1, 0);
    frame({ee_pkg::OP_WREX, 8'h00, 8'h04, 8'h00, 8'h00}, 5, 0);
    settle();
    frame({ee_pkg::OP_WREN}, 1, 0);
    frame({ee_pkg::OP_WREX, 8'h00, 8'h01, 8'h05, 8'h00}, 5, 0);
    frame({ee_pkg::OP_RDEX, 8'h00, 8'h01, 8'h05}, 5, 0);
    check(rd[4], 8'h6B);
  endtask

  initial begin
    #1_000_000;
    fails++;
    summarize();
  end

  initial begin
    rstn = 1'b0;
    ecc = 1'b0;
    wr_ready = 1'b1;
    repeat (16) @(posedge ref_clk);
    #1 rstn = 1'b1;
    tick(8);
    check({standby, so_oe, wr_valid}, 3'b100);
    status(8'h00, 8'h00);
    t_regs();
    t_hold_deselect();
    t_write();
    t_ecc();
    t_legacy();
    t_enhanced();
    summarize();
  end
endmodule
`default_nettype wire
